// *** logic/ucc_map.vh ***
// Purpose: address map, field layout, reset values and timing counts
//          of one serial line channel
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   byte offsets are compared on haddr[7:0]
`ifndef UCC_MAP_VH
`define UCC_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UCC_OFS_CTRL 8'h00
`define UCC_OFS_DIV 8'h04
`define UCC_OFS_TXD 8'h08
`define UCC_OFS_RXD 8'h0C
`define UCC_OFS_STAT 8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define UCC_CTRL_LEN 1:0
`define UCC_CTRL_PAREN 2
`define UCC_CTRL_PARODD 3
`define UCC_CTRL_STOPL 4
`define UCC_CTRL_MODE 6:5
`define UCC_CTRL_DRV 7
`define UCC_CTRL_RST 8'h03
`define UCC_DIV_RST 16'h00F0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define UCC_ST_TXEMPTY 0
`define UCC_ST_TXFULL 1
`define UCC_ST_RXEMPTY 2
`define UCC_ST_RXFULL 3
`define UCC_ST_TXBUSY 4
`define UCC_ST_RMTOFF 5
`define UCC_ST_CTS 6
`define UCC_ST_OVR 7
`define UCC_ST_LVL 14:8

// ----------------------------------------------------------------
// operating modes and flow control characters
// ----------------------------------------------------------------
`define UCC_MODE_PLAIN 2'h0
`define UCC_MODE_SWFC 2'h1
`define UCC_MODE_HWFC 2'h2
`define UCC_MODE_BUS 2'h3
`define UCC_XON 8'h11
`define UCC_XOFF 8'h13

// ----------------------------------------------------------------
// queue size, flow thresholds and clock rates
// ----------------------------------------------------------------
`define UCC_FIFO_DEPTH 64
`define UCC_FIFO_AW 6
`define UCC_RX_HIGH 7'h30
`define UCC_RX_LOW 7'h10
`define UCC_SYS_HZ 25'h17D7840
`define UCC_BASE_HZ 25'h0232800

`endif

// *** logic/ucc_fifo.v ***
// Purpose: synchronous first-in first-out queue with valid/ready
// Assumes: one clock, push and pop may happen in the same cycle
// Notes:   head word is shown while outValid is high
`timescale 1ns/1ps
module ucc_fifo
#(
  parameter WIDTH = 9,
  parameter DEPTH = 64,
  parameter AW = 6
)
(
  input wire clk_sys,
  input wire rst_n,
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output wire inReady,
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady,
  output wire [AW:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wrPtr_ff; // next slot to write
  reg [AW-1:0] rdPtr_ff; // head slot
  reg [AW:0] count_ff; // words held
  wire doPush;
  wire doPop;

  localparam [AW:0] FULL = DEPTH; // fill count when full
  assign inReady = (count_ff != FULL);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_ff];
  assign level = count_ff;
  assign doPush = inValid & inReady;
  assign doPop = outReady & outValid;

  // ----------------------------------------------------------------
  // storage write, no reset needed on data
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (doPush)
      mem[wrPtr_ff] <= inData;
  end

  // ----------------------------------------------------------------
  // pointers and fill count
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doPop)
        rdPtr_ff <= rdPtr_ff + 1'b1;
      if (doPush && !doPop)
        count_ff <= count_ff + 1'b1;
      else if (doPop && !doPush)
        count_ff <= count_ff - 1'b1;
    end
  end

endmodule

// *** logic/ucc_base_tick.v ***
// Purpose: one-cycle enable at the 2.304 MHz base rate
// Assumes: system clock at 25 MHz
// Notes:   fractional accumulator, average rate exact, jitter one cycle
`timescale 1ns/1ps
`include "ucc_map.vh"
module ucc_base_tick
(
  input wire clk_sys,
  input wire rst_n,
  output wire baseTick
);

  localparam [24:0] STEP = `UCC_BASE_HZ; // added each cycle
  localparam [24:0] WRAP = `UCC_SYS_HZ; // one base period
  reg [24:0] acc_ff; // phase accumulator
  reg tick_ff; // registered enable
  wire [24:0] sum;

  assign sum = acc_ff + STEP;
  assign baseTick = tick_ff;

  // ----------------------------------------------------------------
  // accumulate, pulse on each wrap
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff <= 25'h0000000;
      tick_ff <= 1'b0;
    end
    else if (sum >= WRAP)
    begin
      acc_ff <= sum - WRAP;
      tick_ff <= 1'b1;
    end
    else
    begin
      acc_ff <= sum;
      tick_ff <= 1'b0;
    end
  end

endmodule

// *** logic/ucc_channel.v ***
// Purpose: one asynchronous serial channel with AHB-Lite registers
// Assumes: 25 MHz clk_sys, rst_n async active low, word accesses only
// Notes:   a second channel is a second instance with its own registers
//
// Functional notes
// R1: even, odd or no parity, checked
// R2: payload five to eight bits
// R3: stop 1, 1.5 or 2; five bits
// R4: six to eight bits: one or two
// R5: bit time from 2.304 MHz integer division
// R6: divisor 16 bits, one to all ones
// R7: rates up to 2.304 Mbaud; RS232 software-limited
// R8: divisor is 2304000 over rate
// R9: RS485 bus shared by many stations
// R10: no flow control in RS485
// R11: host selects drive or receive direction
// R12: four modes: plain, Xon/Xoff, RTS/CTS, RS485
// R13: hardware RTS/CTS, software Xon/Xoff characters
// R14: separate 64-byte receive and transmit queues
// R15: per-channel independent line parameters
// R16: start low, LSB first, parity, stop high
// R17: parity or stop error flagged with byte
`timescale 1ns/1ps
`include "ucc_map.vh"
module ucc_channel
(
  input wire clk_sys,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire rxdPin,
  input wire ctsPin,
  output wire txdPin,
  output wire rtsPin,
  output wire driveEnable
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_PAR = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [7:0] ctrl_ff; // line parameters and mode
  reg [15:0] div_ff; // baud divisor
  reg [31:0] hrdata_ff; // read data for the data phase
  reg dataWr_ff; // write data phase pending
  reg [7:0] dataAddr_ff; // offset of the pending write
  reg ovr_ff; // receive queue overflow, sticky
  reg [1:0] rxdSync_ff; // line input synchroniser
  reg [1:0] ctsSync_ff; // clear-to-send synchroniser
  reg rts_ff; // ready-to-receive output
  reg [2:0] txState_ff; // transmitter state
  reg [16:0] txCnt_ff; // base ticks in current bit
  reg [7:0] txShift_ff; // outgoing bits
  reg [2:0] txBit_ff; // payload bit index
  reg txPar_ff; // parity of outgoing char
  reg txLine_ff; // serial output level
  reg sentXoff_ff; // last flow char sent was stop
  reg rmtOff_ff; // partner asked us to stop
  reg [2:0] rxState_ff; // receiver state
  reg [16:0] rxCnt_ff; // base ticks in current bit
  reg [7:0] rxShift_ff; // incoming bits
  reg [2:0] rxBit_ff; // payload bit index
  reg rxParBit_ff; // received parity bit
  reg rxWr_ff; // push strobe into receive queue
  reg [8:0] rxWord_ff; // error flag and byte to push
  reg [31:0] nxt_rdMux; // read value chosen at address phase
  wire baseTick, addrPhase, txWrHit, txInReady, txOutValid, txPop;
  wire rxInReady, rxOutValid, rxPop, txEnd, rxEnd, txHold;
  wire wantXoff, sendCtl, rxEnable, rxIn, rxBad, rxFlowChar;
  wire [7:0] addrLow, lenMask, rxAligned;
  wire [8:0] txOutData, rxOutData;
  wire [6:0] txLevel, rxLevel;
  wire [1:0] mode, lenCode;
  wire [2:0] lastIdx;
  wire [15:0] divEff;
  wire [16:0] bitLen, halfLen, stopLen, txLimit, rxLimit;

  // ----------------------------------------------------------------
  // line parameter decode
  // ----------------------------------------------------------------
  assign mode = ctrl_ff[`UCC_CTRL_MODE];
  assign lenCode = ctrl_ff[`UCC_CTRL_LEN]; // 5..8 bits (see R2)
  assign lastIdx = {1'b0, lenCode} + 3'h4;
  assign lenMask = 8'hFF >> (2'h3 - lenCode);
  // zero divisor acts as one (see R6)
  assign divEff = (div_ff == 16'h0000) ? 16'h0001 : div_ff;
  assign bitLen = {1'b0, divEff}; // bit = divisor base ticks (see R5) (see R7) (see R8)
  assign halfLen = (divEff[15:1] == 15'h0000) ? 17'h00001 : {2'h0, divEff[15:1]};
  // 1.5 stops only with five bits, else 2 (see R3) (see R4)
  assign stopLen = !ctrl_ff[`UCC_CTRL_STOPL] ? bitLen :
                   (lenCode == 2'h0) ? (bitLen + halfLen) : {divEff, 1'b0};
  assign txLimit = (txState_ff == ST_STOP) ? stopLen : bitLen;
  assign rxLimit = (rxState_ff == ST_START) ? halfLen : bitLen;
  assign txEnd = baseTick && (txCnt_ff == txLimit - 17'h00001);
  assign rxEnd = baseTick && (rxCnt_ff == rxLimit - 17'h00001);

  // ----------------------------------------------------------------
  // base rate and queues
  // ----------------------------------------------------------------
  ucc_base_tick u_tick
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .baseTick(baseTick)
  );

  // separate 64-entry queues each way (see R14)
  ucc_fifo #(.WIDTH(9), .DEPTH(`UCC_FIFO_DEPTH), .AW(`UCC_FIFO_AW)) u_txq
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(txWrHit),
    .inData({1'b0, hwdata[7:0]}),
    .inReady(txInReady),
    .outValid(txOutValid),
    .outData(txOutData),
    .outReady(txPop),
    .level(txLevel)
  );

  ucc_fifo #(.WIDTH(9), .DEPTH(`UCC_FIFO_DEPTH), .AW(`UCC_FIFO_AW)) u_rxq
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(rxWr_ff),
    .inData(rxWord_ff),
    .inReady(rxInReady),
    .outValid(rxOutValid),
    .outData(rxOutData),
    .outReady(rxPop),
    .level(rxLevel)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addrPhase = hsel & htrans[1] & hready;
  assign addrLow = haddr[7:0];
  assign txWrHit = dataWr_ff && (dataAddr_ff == `UCC_OFS_TXD);
  // a write to a full transmit queue waits here
  assign hreadyout = !(txWrHit && !txInReady);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign rxPop = addrPhase && !hwrite && (addrLow == `UCC_OFS_RXD);

  // read value, sampled at the address phase
  always @*
  begin
    nxt_rdMux = 32'h00000000;
    case (addrLow)
      `UCC_OFS_CTRL: nxt_rdMux = {24'h000000, ctrl_ff};
      `UCC_OFS_DIV: nxt_rdMux = {16'h0000, div_ff};
      // empty queue reads as all zero (see R17)
      `UCC_OFS_RXD: nxt_rdMux = rxOutValid ? {22'h000000, 1'b1, rxOutData} : 32'h00000000;
      `UCC_OFS_STAT:
      begin
        nxt_rdMux[`UCC_ST_TXEMPTY] = !txOutValid;
        nxt_rdMux[`UCC_ST_TXFULL] = !txInReady;
        nxt_rdMux[`UCC_ST_RXEMPTY] = !rxOutValid;
        nxt_rdMux[`UCC_ST_RXFULL] = !rxInReady;
        nxt_rdMux[`UCC_ST_TXBUSY] = (txState_ff != ST_IDLE);
        nxt_rdMux[`UCC_ST_RMTOFF] = rmtOff_ff;
        nxt_rdMux[`UCC_ST_CTS] = ctsSync_ff[1];
        nxt_rdMux[`UCC_ST_OVR] = ovr_ff;
        nxt_rdMux[`UCC_ST_LVL] = rxLevel;
      end
      default: nxt_rdMux = 32'h00000000;
    endcase
  end

  // address capture, register writes, overflow flag
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataWr_ff <= 1'b0;
      dataAddr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      ctrl_ff <= `UCC_CTRL_RST;
      div_ff <= `UCC_DIV_RST;
      ovr_ff <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        dataWr_ff <= addrPhase & hwrite;
        dataAddr_ff <= addrLow;
      end
      if (addrPhase && !hwrite)
        hrdata_ff <= nxt_rdMux;
      // own copy of line settings per channel (see R15)
      if (dataWr_ff && dataAddr_ff == `UCC_OFS_CTRL)
        ctrl_ff <= hwdata[7:0];
      if (dataWr_ff && dataAddr_ff == `UCC_OFS_DIV)
        div_ff <= hwdata[15:0]; // see R6
      // new overflow wins over write-one-to-clear
      if (rxWr_ff && !rxInReady)
        ovr_ff <= 1'b1;
      else if (dataWr_ff && dataAddr_ff == `UCC_OFS_STAT && hwdata[`UCC_ST_OVR])
        ovr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and flow control outputs
  // ----------------------------------------------------------------
  assign rxIn = rxdSync_ff[1];
  assign txdPin = txLine_ff;
  assign rtsPin = rts_ff;
  // RS232 always drives; RS485 drives only when selected (see R11) (see R9)
  assign driveEnable = (mode != `UCC_MODE_BUS) || ctrl_ff[`UCC_CTRL_DRV];

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxdSync_ff <= 2'h3;
      ctsSync_ff <= 2'h0;
      rts_ff <= 1'b1;
    end
    else
    begin
      rxdSync_ff <= {rxdSync_ff[0], rxdPin};
      ctsSync_ff <= {ctsSync_ff[0], ctsPin};
      // ready to receive until the queue reaches the high mark (see R13)
      rts_ff <= (mode != `UCC_MODE_HWFC) || (rxLevel < `UCC_RX_HIGH);
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // stall reasons per mode; RS485 ignores flow control (see R10) (see R12)
  assign txHold = (mode == `UCC_MODE_SWFC) ? rmtOff_ff :
                  (mode == `UCC_MODE_HWFC) ? !ctsSync_ff[1] :
                  (mode == `UCC_MODE_BUS) ? !ctrl_ff[`UCC_CTRL_DRV] : 1'b0;
  // stop/resume partner with flow characters (see R13)
  assign wantXoff = (rxLevel >= `UCC_RX_HIGH) ? 1'b1 :
                    (rxLevel <= `UCC_RX_LOW) ? 1'b0 : sentXoff_ff;
  assign sendCtl = (mode == `UCC_MODE_SWFC) && (wantXoff != sentXoff_ff);
  // start only on a base tick, so the start bit is a whole bit long
  assign txPop = (txState_ff == ST_IDLE) && !sendCtl && txOutValid && !txHold && baseTick;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txState_ff <= ST_IDLE;
      txCnt_ff <= 17'h00000;
      txShift_ff <= 8'h00;
      txBit_ff <= 3'h0;
      txPar_ff <= 1'b0;
      txLine_ff <= 1'b1;
      sentXoff_ff <= 1'b0;
    end
    else
    begin
      if (mode != `UCC_MODE_SWFC)
        sentXoff_ff <= 1'b0;
      // bit timer runs on base ticks while a char is out
      if (txState_ff != ST_IDLE && baseTick)
        txCnt_ff <= txEnd ? 17'h00000 : txCnt_ff + 17'h00001;
      case (txState_ff)
        ST_IDLE:
        begin
          txLine_ff <= 1'b1; // idle high (see R16)
          txCnt_ff <= 17'h00000;
          txBit_ff <= 3'h0;
          if (sendCtl && baseTick)
          begin
            txShift_ff <= wantXoff ? `UCC_XOFF : `UCC_XON;
            txPar_ff <= ^((wantXoff ? `UCC_XOFF : `UCC_XON) & lenMask)
                        ^ ctrl_ff[`UCC_CTRL_PARODD];
            sentXoff_ff <= wantXoff;
            txLine_ff <= 1'b0;
            txState_ff <= ST_START;
          end
          else if (txPop)
          begin
            txShift_ff <= txOutData[7:0];
            // even or odd parity over the payload (see R1)
            txPar_ff <= ^(txOutData[7:0] & lenMask) ^ ctrl_ff[`UCC_CTRL_PARODD];
            txLine_ff <= 1'b0; // start bit low (see R16)
            txState_ff <= ST_START;
          end
        end
        ST_START:
        begin
          if (txEnd)
          begin
            txLine_ff <= txShift_ff[0]; // LSB first (see R16)
            txState_ff <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (txEnd && txBit_ff == lastIdx)
          begin
            txLine_ff <= ctrl_ff[`UCC_CTRL_PAREN] ? txPar_ff : 1'b1; // see R1
            txState_ff <= ctrl_ff[`UCC_CTRL_PAREN] ? ST_PAR : ST_STOP;
          end
          else if (txEnd)
          begin
            txLine_ff <= txShift_ff[1];
            txShift_ff <= {1'b0, txShift_ff[7:1]};
            txBit_ff <= txBit_ff + 3'h1;
          end
        end
        ST_PAR:
        begin
          if (txEnd)
          begin
            txLine_ff <= 1'b1;
            txState_ff <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (txEnd)
            txState_ff <= ST_IDLE; // stop length from stopLen (see R3)
        end
        default: txState_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // listen only while not driving the shared bus (see R11)
  assign rxEnable = !((mode == `UCC_MODE_BUS) && ctrl_ff[`UCC_CTRL_DRV]);
  assign rxAligned = (rxShift_ff >> (2'h3 - lenCode)) & lenMask;
  // parity mismatch or low stop bit marks the char (see R17) (see R1)
  assign rxBad = (ctrl_ff[`UCC_CTRL_PAREN] &&
                  (rxParBit_ff != (^rxAligned ^ ctrl_ff[`UCC_CTRL_PARODD])))
                 || !rxIn;
  assign rxFlowChar = (mode == `UCC_MODE_SWFC) && !rxBad &&
                      (rxAligned == `UCC_XON || rxAligned == `UCC_XOFF);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState_ff <= ST_IDLE;
      rxCnt_ff <= 17'h00000;
      rxShift_ff <= 8'h00;
      rxBit_ff <= 3'h0;
      rxParBit_ff <= 1'b0;
      rxWr_ff <= 1'b0;
      rxWord_ff <= 9'h000;
      rmtOff_ff <= 1'b0;
    end
    else
    begin
      rxWr_ff <= 1'b0;
      if (mode != `UCC_MODE_SWFC)
        rmtOff_ff <= 1'b0;
      if (rxState_ff != ST_IDLE && baseTick)
        rxCnt_ff <= rxEnd ? 17'h00000 : rxCnt_ff + 17'h00001;
      case (rxState_ff)
        ST_IDLE:
        begin
          rxCnt_ff <= 17'h00000;
          rxBit_ff <= 3'h0;
          if (rxEnable && !rxIn)
            rxState_ff <= ST_START; // falling edge opens a frame (see R16)
        end
        ST_START:
        begin
          if (rxEnd)
            rxState_ff <= rxIn ? ST_IDLE : ST_DATA; // mid-bit check drops glitches
        end
        ST_DATA:
        begin
          if (rxEnd)
          begin
            rxShift_ff <= {rxIn, rxShift_ff[7:1]};
            rxBit_ff <= rxBit_ff + 3'h1;
            if (rxBit_ff == lastIdx)
              rxState_ff <= ctrl_ff[`UCC_CTRL_PAREN] ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR:
        begin
          if (rxEnd)
          begin
            rxParBit_ff <= rxIn;
            rxState_ff <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (rxEnd)
          begin
            rxState_ff <= ST_IDLE;
            if (rxFlowChar)
              rmtOff_ff <= (rxAligned == `UCC_XOFF); // see R13
            else
            begin
              rxWr_ff <= 1'b1;
              rxWord_ff <= {rxBad, rxAligned}; // see R17
            end
          end
        end
        default: rxState_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

// *** verification/ucc_channel_sva.sv ***
// Purpose: port checks of one serial channel
// Assumes: one clock, async active-low reset
// Notes:   control word shadowed from bus writes
`timescale 1ns/1ps
module ucc_channel_sva
(
  input wire clk_sys,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire txdPin,
  input wire rtsPin,
  input wire driveEnable
);
  // ------------------------------
  // bus phase tracking
  // ------------------------------
  reg phOn_ff; // data phase pending
  reg phWr_ff; // pending phase is a write
  reg [7:0] phA_ff; // pending offset
  reg [7:0] ctl_ff; // shadow of the control word
  wire busTake = hsel && htrans[1] && hready;
  wire busRd = busTake && !hwrite;
  // follow address phases, capture control writes
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      phOn_ff <= 1'b0;
      phWr_ff <= 1'b0;
      phA_ff <= 8'h00;
      ctl_ff <= 8'h03;
    end
    else if (hready)
    begin
      if (phOn_ff && phWr_ff && phA_ff == 8'h00)
        ctl_ff <= hwdata[7:0];
      phOn_ff <= busTake;
      phWr_ff <= hwrite;
      phA_ff <= haddr[7:0];
    end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  read_nowait_a: assert property (busRd |=> hreadyout) else $error("read waited");
  wait_cause_a:
    assert property (!hreadyout |-> phOn_ff && phWr_ff && phA_ff == 8'h08)
    else $error("wait without full queue");
  unmapped_zero_a:
    assert property (busRd && (haddr[7:0] > 8'h13 || haddr[7:0] == 8'h08) |=> hrdata == 32'h0)
    else $error("empty place read nonzero");
  level_sane_a:
    assert property (busRd && haddr[7:0] == 8'h10 |=> hrdata[14:8] <= 7'h40
      && hrdata[2] == (hrdata[14:8] == 7'h00) && !(hrdata[0] && hrdata[1]))
    else $error("queue status inconsistent");
  rts_plain_a:
    assert property ((ctl_ff[6:5] != 2'h2)[*2] |-> rtsPin) else $error("rts low outside mode");
  drive_dir_a:
    assert property (driveEnable == (ctl_ff[6:5] != 2'h3 || ctl_ff[7]))
    else $error("driver enable wrong");
  bus_quiet_a:
    assert property (ctl_ff[6:5] == 2'h3 && !ctl_ff[7] |-> txdPin) else $error("sent on bus");
  start_len_a:
    assert property ($fell(txdPin) |-> !txdPin[*8]) else $error("start bit short");
  cover property ($fell(txdPin));
  cover property (!hreadyout);
  cover property (ctl_ff[6:5] == 2'h3 && !ctl_ff[7]);
endmodule
bind ucc_channel ucc_channel_sva ucc_channel_sva_i (.*);

// *** verification/ucc_line_partner.sv ***
// Purpose: remote station on the serial line
// Assumes: bit time and framing set by the bench
// Notes:   listens only while the channel drives the line
`timescale 1ns/1ps
module ucc_line_partner
(
  input wire txdPin,
  input wire driveEnable,
  output logic rxdPin,
  output logic ctsPin
);
  real bitNs = 434.0; // one bit time
  int nBits = 8; // payload length
  bit parEn; // parity present
  bit parOdd; // odd parity
  logic [8:0] got; // error flag and payload
  logic p; // parity mismatch
  int i;
  event gotEv; // one frame decoded
  // line idles high, peer allows sending
  initial
  begin
    rxdPin = 1'b1;
    ctsPin = 1'b1;
  end
  // mid-bit frame receiver, one listener on the bus
  always @(negedge txdPin)
    if (driveEnable)
    begin
      #(bitNs / 2);
      got = 9'h000;
      for (i = 0; i < nBits; i++)
      begin
        #(bitNs);
        got[i] = txdPin;
      end
      p = 1'b0;
      if (parEn)
      begin
        #(bitNs);
        p = ^{got[7:0], txdPin} ^ parOdd;
      end
      #(bitNs);
      got[8] = p | !txdPin;
      ->gotEv;
    end
  // start low, payload lsb first, parity, two stop bits
  task sendChar(input logic [7:0] d, input logic bad);
    logic [7:0] m;
    int j;
    m = d & (8'hFF >> (8 - nBits));
    rxdPin = 1'b0;
    #(bitNs);
    for (j = 0; j < nBits; j++)
    begin
      rxdPin = m[j];
      #(bitNs);
    end
    if (parEn)
    begin
      rxdPin = ^m ^ parOdd ^ bad;
      #(bitNs);
    end
    rxdPin = 1'b1;
    #(2 * bitNs);
  endtask
endmodule

// *** verification/ucc_channel_test.sv ***
// Purpose: self-checking bench of one serial channel
// Assumes: remote station model on the line side
// Notes:   drivers queue expected results, monitors compare
`timescale 1ns/1ps
`include "ucc_map.vh"
module ucc_channel_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic rdyS; // hready as it stands before the next edge
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, txdPin, rtsPin, driveEnable, rxdPin, ctsPin;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int k;
  logic [15:0] rnd = 16'hC4E1; // seed 50401
  logic [31:0] rdQ[$]; // expected register reads
  logic [8:0] serQ[$]; // expected frames at the station
  logic [31:0] rdGot;
  logic [7:0] msk; // payload mask
  event rdEv;
  ucc_channel ucc_channel_i (.*, .hready(hreadyout));
  ucc_line_partner ucc_line_partner_i (.*);
  // 25 MHz clock and cycle ceiling
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) rdyS <= hreadyout;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fails++;
      finish_test;
    end
  end
  // monitors take the oldest note
  always @(rdEv) check("register", rdQ.pop_front(), rdGot);
  always @(ucc_line_partner_i.gotEv) check("frame", serQ.pop_front(), ucc_line_partner_i.got);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single bus transfer, waits on hready in both phases
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (rdyS !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (rdyS !== 1'b1);
    rdGot = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(a, 1'b0, 32'h0);
    ->rdEv;
  endtask
  task cfg(input logic [7:0] c, input logic [15:0] dv);
    bus(8'h00, 1'b1, {24'h0, c});
    bus(8'h04, 1'b1, {16'h0, dv});
    ucc_line_partner_i.nBits = c[1:0] + 5;
    ucc_line_partner_i.parEn = c[2];
    ucc_line_partner_i.parOdd = c[3];
    ucc_line_partner_i.bitNs = dv * 1.0e9 / 2304000.0;
    msk = 8'hFF >> (3 - c[1:0]);
  endtask
  task tx(input logic [7:0] d);
    serQ.push_back({1'b0, d & msk});
    bus(8'h08, 1'b1, {24'h0, d});
  endtask
  task drain;
    wait (serQ.size() == 0);
    @(posedge clk_sys);
  endtask
  task rxc(input logic [7:0] d, input logic bad);
    ucc_line_partner_i.sendChar(d, bad);
    @(posedge clk_sys);
    rd(8'h0C, {22'h0, 1'b1, bad, d & msk});
  endtask
  task finish_test;
    $display("counts checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'h00, 32'h3);
    rd(8'h04, 32'hF0);
    rd(8'h10, 32'h45);
    bus(8'h14, 1'b1, 32'hFFFF);
    rd(8'h14, 32'h0);
    $display("reset values done");
    for (k = 0; k < 12; k++)
    begin
      rnd = lfsr(rnd);
      cfg({3'h0, k[2] ^ k[0], k[3:2] == 2, k[3:2] != 0, k[1:0]}, rnd[1:0] + 1);
      tx(rnd[15:8]);
      drain;
      rxc(rnd[7:0], k[0] & (k[3:2] != 0));
    end
    $display("framing done");
    cfg(8'h63, 16'h1);
    tx(8'hA5);
    rxc(8'h3C, 1'b0);
    check("held", 1, serQ.size());
    cfg(8'hE3, 16'h1);
    drain;
    ucc_line_partner_i.sendChar(8'h3C, 1'b0);
    @(posedge clk_sys);
    rd(8'h0C, 32'h0);
    cfg(8'h43, 16'h1);
    ucc_line_partner_i.ctsPin <= 1'b0;
    tx(8'h5A);
    repeat (400) @(posedge clk_sys);
    check("cts stall", 1, serQ.size());
    check("rts", 1, rtsPin);
    ucc_line_partner_i.ctsPin <= 1'b1;
    drain;
    cfg(8'h23, 16'h1);
    ucc_line_partner_i.sendChar(`UCC_XOFF, 1'b0);
    @(posedge clk_sys);
    rd(8'h10, 32'h65);
    tx(8'h81);
    repeat (400) @(posedge clk_sys);
    check("xoff stall", 1, serQ.size());
    ucc_line_partner_i.sendChar(`UCC_XON, 1'b0);
    drain;
    $display("modes done");
    cfg(8'h03, 16'h1);
    for (k = 0; k < 66; k++) tx(k[7:0]);
    drain;
    for (k = 0; k < 65; k++) ucc_line_partner_i.sendChar(k[7:0] ^ 8'h5A, 1'b0);
    @(posedge clk_sys);
    rd(8'h10, 32'h40C9);
    for (k = 0; k < 64; k++) rd(8'h0C, {22'h0, 2'h2, k[7:0] ^ 8'h5A});
    rd(8'h10, 32'hC5);
    bus(8'h10, 1'b1, 32'h80);
    rd(8'h10, 32'h45);
    $display("queues done");
    finish_test;
  end
endmodule
